// File: cfgpin_far_side.sv
/*
  Behavioural model of the external logic wired to the configurable pin.
  Assumes the bench says when the far side drives; the pad resolves
  from every party's enable and the weak pulls.
*/
module cfgpin_far_side (
  input  wire logic clock_i,
  input  wire logic drive_i,
  input  wire logic oe_i,
  input  wire logic pull_up_i,
  input  wire logic pull_down_i,
  input  wire logic ext_en_i,
  input  wire logic ext_level_i,
  output logic      pad_o
);
  // Undriven, unpulled pad wanders so a stale level never passes
  logic float_q = 1'b0;

  always_ff @(posedge clock_i) begin
    float_q <= ~float_q;
  end

  always_comb begin
    if (oe_i) begin
      pad_o = drive_i;
    end else if (ext_en_i) begin
      pad_o = ext_level_i;
    end else if (pull_down_i) begin
      pad_o = 1'b0;
    end else if (pull_up_i) begin
      pad_o = 1'b1;
    end else begin
      pad_o = float_q;
    end
  end
endmodule // cfgpin_far_side

// File: cfgpin_map.svh
/*
  Constants for the configurable pin function selector: code widths,
  clock synthesis figures and reset values.
  Assumes inclusion by the package and the selector module only.
*/
// Functional notes
// [RQ1] Pin function comes from non-volatile configuration, fixed once loaded.
// [RQ2] Static choices: high impedance, constant one, constant zero.
// [RQ3] Power enable: low after USB configuration, high during suspend.
// [RQ4] Outside: enable suspend pull-down when power enable drives a switch.
// [RQ5] Sleep indicator: low throughout USB suspend, high otherwise.
// [RQ6] Clock choices drive free-running 24, 12 or 6 MHz clocks.
// [RQ7] Any pin clock stops during USB suspend and resumes afterwards.
// [RQ8] General-purpose choice: level and direction set by bit-bang mode.
// [RQ9] Charger detect: high while a dedicated charging port is seen.
// [RQ10] Inverted charger detect: open drain, pulls low when charging seen.
// [RQ11] Write strobe choice outputs the active-low bit-bang write strobe.
// [RQ12] Read strobe choice outputs the active-low bit-bang read strobe.
// [RQ13] Transmit-empty choice shows the USB-bound buffer empty, active low.
// [RQ14] Receive-full choice shows the USB-received buffer status, active low.
// [RQ15] Bus voltage sense: pin is an input reporting VBUS presence.
// [RQ16] Timestamp: pin inverts once per start-of-frame, holds between.
// [RQ17] Keep-awake: active-low input that blocks suspend when unplugged.
// [RQ18] Input pins pulled up; option pulls them low during suspend.
// [RQ19] Pin clocks derive from the 12 MHz reference via multiply/divide.
// [RQ20] Reported receive and transmit buffers hold 512 bytes each.
// [RQ21] Enumerated select; unused codes give high impedance; load after reset.
`ifndef CFGPIN_MAP_SVH
`define CFGPIN_MAP_SVH

`define CPM_SEL_W      5
`define CPM_FUNC_COUNT 5'h12
`define CPM_BUF_BYTES  512
`define CPM_SYS_MHZ    100
`define CPM_OSC_MHZ    12
`define CPM_MUL_FAST   2
`define CPM_DIV_SLOW   2
`define CPM_ACC_W      16
`define CPM_INC_MID    ((`CPM_OSC_MHZ << `CPM_ACC_W) / `CPM_SYS_MHZ)
`define CPM_INC_FAST   (`CPM_INC_MID * `CPM_MUL_FAST)
`define CPM_INC_SLOW   (`CPM_INC_MID / `CPM_DIV_SLOW)
`define CPM_PWR_RST    1'b1
`define CPM_STAMP_RST  1'b0

`endif

// File: cfgpin_pkg.sv
/*
  Types for the configurable pin function selector.
  Assumes the map header sits beside it.
*/
`include "cfgpin_map.svh"
package cfgpin_pkg;
  typedef logic [`CPM_SEL_W-1:0] sel_code_t;
  typedef enum logic [`CPM_SEL_W-1:0] {
    FN_TRISTATE, FN_DRIVE1, FN_DRIVE0, FN_POWER_ENABLE_N, FN_SLEEP,
    FN_CLK_FAST, FN_CLK_MID, FN_CLK_SLOW, FN_GPIO,
    FN_CHG, FN_CHG_N, FN_WR_STB, FN_RD_STB,
    FN_TX_EMPTY, FN_RX_FULL, FN_VBUS, FN_STAMP, FN_KEEP_AWAKE
  } pin_func_e;
endpackage

// File: config_pin_function_mux.sv
/*
  Function selector for the single configurable pin: decodes the stored
  selection, drives pad level and enable, pulls, and sense outputs.
  Assumes status inputs are on clock_i; only the pad input is asynchronous.
*/
`include "cfgpin_map.svh"
module config_pin_function_mux (
  input  wire logic                 clock_i,
  input  wire logic                 nrst_i,
  input  wire cfgpin_pkg::sel_code_t config_select_i,
  input  wire logic                 config_pulldown_suspend_i,
  input  wire logic                 usb_configured_i,
  input  wire logic                 usb_suspend_i,
  input  wire logic                 charger_detect_i,
  input  wire logic                 gpio_out_i,
  input  wire logic                 gpio_dir_i,
  input  wire logic                 bitbang_write_strobe_n_i,
  input  wire logic                 bitbang_read_strobe_n_i,
  input  wire logic                 tx_buffer_empty_n_i,
  input  wire logic                 rx_buffer_full_n_i,
  input  wire logic                 sof_pulse_i,
  input  wire logic                 config_pin_zero_i,
  output logic                      config_pin_zero_o,
  output logic                      config_pin_zero_oe_o,
  output logic                      pull_up_en_o,
  output logic                      pull_down_en_o,
  output logic                      gpio_in_o,
  output logic                      vbus_present_o,
  output logic                      keep_awake_o,
  output cfgpin_pkg::pin_func_e     active_function_o
);
  import cfgpin_pkg::*;

  pin_func_e func_q;
  logic      loaded_q;
  logic      power_enable_n_q;
  logic      stamp_q;
  logic      pin_sync;
  logic      clock_out_fast;
  logic      clock_out_mid;
  logic      clock_out_slow;
  logic      clk_run;
  logic      sel_known;
  pin_func_e func_d;
  logic      pad_d;
  logic      oe_d;
  logic      pull_dn_d;
  logic      power_enable_n_d;
  logic      stamp_d;

  // Pad input crosses into clock_i before any decode looks at it
  sync2 #(
    .W (1)
  ) u_pad_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (config_pin_zero_i),
    .sync_o  (pin_sync)
  );

  // Selection is caught once on the first edge after reset release
  // and never follows later changes of the stored value.
  assign sel_known = config_select_i < `CPM_FUNC_COUNT;
  assign func_d    = sel_known ? pin_func_e'(config_select_i)
                               : FN_TRISTATE; // RQ21

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      loaded_q <= 1'b0;
      func_q   <= FN_TRISTATE;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      func_q   <= func_d; // RQ1
    end
  end

  // Pin clocks: a 12 MHz base, doubled and halved
  assign clk_run = !usb_suspend_i; // RQ7

  tick_nco #(
    .ACC_W (`CPM_ACC_W),
    .INC   (`CPM_INC_FAST)
  ) u_nco_fast (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .run_i   (clk_run),
    .clk_o   (clock_out_fast)
  ); // RQ19

  tick_nco #(
    .ACC_W (`CPM_ACC_W),
    .INC   (`CPM_INC_MID)
  ) u_nco_mid (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .run_i   (clk_run),
    .clk_o   (clock_out_mid)
  ); // RQ19

  tick_nco #(
    .ACC_W (`CPM_ACC_W),
    .INC   (`CPM_INC_SLOW)
  ) u_nco_slow (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .run_i   (clk_run),
    .clk_o   (clock_out_slow)
  ); // RQ19

  // Power enable stays high until the host configures us
  assign power_enable_n_d = usb_suspend_i    ? 1'b1 :
                            usb_configured_i ? 1'b0 :
                            power_enable_n_q; // RQ3
  // Start-of-frame toggle
  assign stamp_d = sof_pulse_i ? !stamp_q : stamp_q; // RQ16

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      power_enable_n_q <= `CPM_PWR_RST;
      stamp_q          <= `CPM_STAMP_RST;
    end else begin
      power_enable_n_q <= power_enable_n_d;
      stamp_q          <= stamp_d;
    end
  end

  // Output function decode
  always_comb begin
    pad_d = 1'b0;
    oe_d  = 1'b1;
    case (func_q)
      FN_TRISTATE:   oe_d  = 1'b0; // RQ2
      FN_DRIVE1:     pad_d = 1'b1; // RQ2
      FN_DRIVE0:     pad_d = 1'b0; // RQ2
      FN_POWER_ENABLE_N:      pad_d = power_enable_n_q; // RQ3
      FN_SLEEP:      pad_d = !usb_suspend_i; // RQ5
      FN_CLK_FAST:   pad_d = clock_out_fast; // RQ6
      FN_CLK_MID:    pad_d = clock_out_mid; // RQ6
      FN_CLK_SLOW:   pad_d = clock_out_slow; // RQ6
      FN_GPIO: begin
        pad_d = gpio_out_i; // RQ8
        oe_d  = gpio_dir_i; // RQ8
      end
      FN_CHG:        pad_d = charger_detect_i; // RQ9
      FN_CHG_N: begin
        pad_d = 1'b0; // RQ10
        oe_d  = charger_detect_i; // RQ10
      end
      FN_WR_STB:     pad_d = bitbang_write_strobe_n_i; // RQ11
      FN_RD_STB:     pad_d = bitbang_read_strobe_n_i; // RQ12
      FN_TX_EMPTY:   pad_d = tx_buffer_empty_n_i; // RQ13 RQ20
      FN_RX_FULL:    pad_d = rx_buffer_full_n_i; // RQ14 RQ20
      FN_VBUS:       oe_d  = 1'b0; // RQ15
      FN_STAMP:      pad_d = stamp_q; // RQ16
      FN_KEEP_AWAKE: oe_d  = 1'b0; // RQ17
      default:       oe_d  = 1'b0; // RQ21
    endcase
  end

  // Weak pulls only while the pad is not driven; pull-down in suspend
  // when the option is set, so a switched-off load sees no back-feed.
  assign pull_dn_d = config_pulldown_suspend_i && usb_suspend_i; // RQ18

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      config_pin_zero_o    <= 1'b0;
      config_pin_zero_oe_o <= 1'b0;
      pull_up_en_o         <= 1'b1;
      pull_down_en_o       <= 1'b0;
      gpio_in_o            <= 1'b0;
      vbus_present_o       <= 1'b0;
      keep_awake_o         <= 1'b0;
      active_function_o    <= FN_TRISTATE;
    end else begin
      config_pin_zero_o    <= pad_d;
      config_pin_zero_oe_o <= oe_d;
      pull_up_en_o         <= !oe_d && !pull_dn_d; // RQ18
      pull_down_en_o       <= !oe_d && pull_dn_d; // RQ18
      gpio_in_o            <= (func_q == FN_GPIO) && pin_sync; // RQ8
      vbus_present_o       <= (func_q == FN_VBUS) && pin_sync; // RQ15
      keep_awake_o         <= (func_q == FN_KEEP_AWAKE) && !pin_sync; // RQ17
      active_function_o    <= func_q;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_suspended;
    usb_suspend_i [*3];
  endsequence

  sequence s_running_mid;
    (loaded_q && func_q == FN_CLK_MID && !usb_suspend_i) [*8];
  endsequence

  sequence s_awake_held;
    (loaded_q && func_q == FN_KEEP_AWAKE && !config_pin_zero_i) [*3];
  endsequence

  property p_func_fixed;
    loaded_q |=> $stable(func_q) && loaded_q;
  endproperty
  a_func_fixed: assert property (p_func_fixed) // RQ1
    else $error("pin function changed after load");

  property p_unknown_code;
    (!loaded_q && !sel_known) |=> (func_q == FN_TRISTATE)
      ##1 !config_pin_zero_oe_o;
  endproperty
  a_unknown_code: assert property (p_unknown_code) // RQ21
    else $error("unused select code did not give high impedance");

  property p_drive_const;
    (loaded_q && (func_q == FN_DRIVE1 || func_q == FN_DRIVE0))
      |=> config_pin_zero_oe_o
          && (config_pin_zero_o == ($past(func_q) == FN_DRIVE1));
  endproperty
  a_drive_const: assert property (p_drive_const) // RQ2
    else $error("constant drive choice wrong");

  property p_power_enable_n;
    (loaded_q && func_q == FN_POWER_ENABLE_N && usb_suspend_i)
      |-> ##2 config_pin_zero_o;
  endproperty
  a_power_enable_n: assert property (p_power_enable_n) // RQ3
    else $error("power enable not high in suspend");

  property p_power_enable_n_on;
    (loaded_q && func_q == FN_POWER_ENABLE_N && usb_configured_i
      && !usb_suspend_i) ##1 !usb_suspend_i |=> !config_pin_zero_o;
  endproperty
  a_power_enable_n_on: assert property (p_power_enable_n_on) // RQ3
    else $error("power enable not low after configuration");

  property p_sleep;
    (loaded_q && func_q == FN_SLEEP)
      |=> config_pin_zero_o == !$past(usb_suspend_i);
  endproperty
  a_sleep: assert property (p_sleep) // RQ5
    else $error("sleep indicator wrong");

  property p_clk_stop;
    (loaded_q && (func_q == FN_CLK_FAST || func_q == FN_CLK_MID
      || func_q == FN_CLK_SLOW)) ##0 s_suspended |=> !config_pin_zero_o;
  endproperty
  a_clk_stop: assert property (p_clk_stop) // RQ7
    else $error("pin clock runs during suspend");

  property p_clk_runs;
    s_running_mid |-> ##[1:12] $changed(config_pin_zero_o);
  endproperty
  a_clk_runs: assert property (p_clk_runs) // RQ6
    else $error("pin clock stuck outside suspend");

  property p_chg_od;
    (loaded_q && func_q == FN_CHG_N) |=> !config_pin_zero_o
      && (config_pin_zero_oe_o == $past(charger_detect_i));
  endproperty
  a_chg_od: assert property (p_chg_od) // RQ10
    else $error("open-drain charger output wrong");

  property p_wr_strobe;
    (loaded_q && func_q == FN_WR_STB)
      |=> config_pin_zero_o == $past(bitbang_write_strobe_n_i);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) // RQ11
    else $error("write strobe not passed to pin");

  property p_stamp;
    (loaded_q && func_q == FN_STAMP && sof_pulse_i)
      |-> ##2 config_pin_zero_o != $past(config_pin_zero_o);
  endproperty
  a_stamp: assert property (p_stamp) // RQ16
    else $error("timestamp did not toggle on frame");

  property p_keep_awake;
    s_awake_held |=> ##1 keep_awake_o;
  endproperty
  a_keep_awake: assert property (p_keep_awake) // RQ17
    else $error("keep-awake input not honoured");

  property p_pull;
    (!oe_d && config_pulldown_suspend_i && usb_suspend_i)
      |=> pull_down_en_o && !pull_up_en_o;
  endproperty
  a_pull: assert property (p_pull) // RQ18
    else $error("suspend pull-down not applied");
endmodule // config_pin_function_mux

// File: config_pin_function_mux_test.sv
/*
  Self-checking bench for the configurable pin selector.
  Assumes a 100 MHz clock, a fresh reset per function code and
  the far-side model beside the pad.
*/
module config_pin_function_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cfgpin_pkg::*;
  localparam int SYS_MHZ = 100;
  logic       clk, nrst, pdn_opt, cfgd, susp, chg, gout, gdir;
  logic       sof, ext_en, ext_lvl, pad, oe, pu, pd, gin, vbus, awake;
  logic       pad_in;
  logic [3:0] stb;
  sel_code_t  sel;
  pin_func_e  func;
  int         error_cnt, num_checks, c;
  logic [4:0] sc [5] = '{5'h00, 5'h01, 5'h02, 5'h12, 5'h1F};

  config_pin_function_mux i_config_pin_function_mux (
    .clock_i(clk), .nrst_i(nrst), .config_select_i(sel),
    .config_pulldown_suspend_i(pdn_opt), .usb_configured_i(cfgd),
    .usb_suspend_i(susp), .charger_detect_i(chg), .gpio_out_i(gout),
    .gpio_dir_i(gdir), .bitbang_write_strobe_n_i(stb[3]),
    .bitbang_read_strobe_n_i(stb[2]), .tx_buffer_empty_n_i(stb[1]),
    .rx_buffer_full_n_i(stb[0]), .sof_pulse_i(sof),
    .config_pin_zero_i(pad_in), .config_pin_zero_o(pad),
    .config_pin_zero_oe_o(oe), .pull_up_en_o(pu), .pull_down_en_o(pd),
    .gpio_in_o(gin), .vbus_present_o(vbus), .keep_awake_o(awake),
    .active_function_o(func));

  cfgpin_far_side i_cfgpin_far_side (
    .clock_i(clk), .drive_i(pad), .oe_i(oe), .pull_up_i(pu),
    .pull_down_i(pd), .ext_en_i(ext_en), .ext_level_i(ext_lvl),
    .pad_o(pad_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strap is sampled once after reset; later changes must not stick
  task automatic load(input logic [4:0] code);
    nrst = 1'b0;
    sel = code;
    step(12);
    nrst = 1'b1;
    step(2);
    sel = ~code;
    step(3);
    chk(func, (code > 5'h11) ? 32'h0 : 32'(code));
  endtask

  // Transitions seen on the pad over n cycles
  task automatic edges(input int n, output int cnt);
    logic last;
    cnt = 0;
    last = pad;
    repeat (n) begin
      @(negedge clk);
      if (pad !== last) cnt++;
      last = pad;
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #300us;
    error_cnt++;
    results();
  end

  initial begin
    {nrst, pdn_opt, cfgd, susp, chg, gout, gdir} = '0;
    {sof, ext_en, ext_lvl, sel} = '0;
    stb = 4'hF;
    for (int i = 0; i < 5; i++) begin
      load(sc[i]);
      chk({oe, pad}, {sc[i] == 5'h01 || sc[i] == 5'h02, sc[i] == 5'h01});
      chk(pu, sc[i] != 5'h01 && sc[i] != 5'h02);
    end
    load(5'h00);
    {pdn_opt, susp} = 2'b11;
    step(3);
    chk({pu, pd}, 2'b01);
    susp = 1'b0;
    step(3);
    chk({pu, pd}, 2'b10);
    pdn_opt = 1'b0;
    $display("test static done");
    pdn_opt = 1'b1;
    load(5'h03);
    chk(pad, 1);
    cfgd = 1'b1;
    step(3);
    chk(pad, 0);
    susp = 1'b1;
    step(3);
    chk(pad, 1);
    chk({pu, pd}, 2'b00);
    pdn_opt = 1'b0;
    load(5'h04);
    chk(pad, 0);
    susp = 1'b0;
    step(3);
    chk(pad, 1);
    $display("test power done");
    for (int k = 0; k < 3; k++) begin
      load(5'h05 + 5'(k));
      edges(1000, c);
      chk(c >= (20 * (24 >> k) * 100 / SYS_MHZ) - 4 &&
          c <= (20 * (24 >> k) * 100 / SYS_MHZ) + 4, 1);
      susp = 1'b1;
      step(4);
      edges(100, c);
      chk(c, 0);
      chk(pad, 0);
      susp = 1'b0;
      step(4);
      edges(50, c);
      chk(c > 0, 1);
    end
    $display("test clocks done");
    load(5'h08);
    {gdir, gout} = 2'b11;
    step(3);
    chk({oe, pad}, 2'b11);
    {gdir, ext_en, ext_lvl} = 3'b010;
    step(5);
    chk({oe, gin}, 2'b00);
    ext_lvl = 1'b1;
    step(5);
    chk(gin, 1);
    ext_en = 1'b0;
    for (int m = 9; m < 11; m++) begin
      load(5'(m));
      chg = 1'b1;
      step(3);
      chk({oe, pad}, (m == 9) ? 2'b11 : 2'b10);
      chg = 1'b0;
      step(3);
      chk({oe, pad}, (m == 9) ? 2'b10 : 2'b00);
    end
    $display("test gpio charger done");
    for (int s = 11; s < 15; s++) begin
      load(5'(s));
      stb = 4'h1 << (14 - s);
      step(3);
      chk({oe, pad}, 2'b11);
      stb = ~stb;
      step(3);
      chk({oe, pad}, 2'b10);
      stb = 4'hF;
    end
    $display("test strobes done");
    load(5'h0F);
    {ext_en, ext_lvl} = 2'b11;
    step(5);
    chk({oe, vbus}, 2'b01);
    ext_lvl = 1'b0;
    step(5);
    chk(vbus, 0);
    load(5'h11);
    step(5);
    chk(awake, 1);
    ext_lvl = 1'b1;
    step(5);
    chk(awake, 0);
    ext_en = 1'b0;
    load(5'h10);
    chk(pad, 0);
    sof = 1'b1;
    step(1);
    sof = 1'b0;
    step(3);
    chk(pad, 1);
    step(20);
    chk(pad, 1);
    sof = 1'b1;
    step(2);
    sof = 1'b0;
    step(4);
    chk(pad, 1);
    $display("test sense stamp done");
    results();
  end
endmodule // config_pin_function_mux_test

// File: sync2.sv
/*
  Two flip-flop synchroniser for asynchronous pad levels.
  Assumes a single system clock and synchronous active-low reset.
*/
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      // Reset to the pulled-up idle level: a low here would fake a
      // keep-awake request on the first cycles after reset
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // sync2

// File: tick_nco.sv
/*
  Phase accumulator clock synthesiser; output is the accumulator top bit.
  Assumes INC below half the accumulator range. Average rate is INC/2^ACC_W
  of the clock, edges carry one system cycle of jitter.
*/
module tick_nco #(
  parameter int unsigned ACC_W = 16,
  parameter int unsigned INC   = 1
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic run_i,
  output logic      clk_o
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;

  assign acc_d = run_i ? acc_q + INC[ACC_W-1:0] : '0;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      acc_q <= '0;
      clk_o <= 1'b0;
    end else begin
      acc_q <= acc_d;
      clk_o <= acc_q[ACC_W-1];
    end
  end
endmodule // tick_nco
